// ===== logic/dtsr_conv_seq.sv
// Conversion sequencer: local then two remote phases, then interval wait
// Assumes one-shot is a one-cycle pulse from the register logic
`timescale 1ns/100ps
`include "dtsr_defines.svh"
module dtsr_conv_seq #(
  parameter logic [31:0] LOCAL_CYC = 32'h1,
  parameter logic [31:0] REMOTE_CYC = 32'h1,
  parameter logic [31:0] PER0_CYC = 32'h3,
  parameter logic [31:0] PER1_CYC = 32'h4,
  parameter logic [31:0] PER2_CYC = 32'h5,
  parameter logic [31:0] PER3_CYC = 32'h6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic standby,
  input wire logic one_shot,
  input wire logic [1:0] interval_sel,
  output dtsr_pkg::dtsr_state_t state,
  output logic cycle_start,
  output logic phase_done
);
  dtsr_pkg::dtsr_state_t state_q;
  dtsr_pkg::dtsr_state_t state_d;
  logic [31:0] phase_cnt_q;
  logic [31:0] per_cnt_q;
  logic [31:0] per_lim_q;
  logic [31:0] phase_lim;
  logic measuring;

  function automatic logic [31:0] period_of(input logic [1:0] sel);
    case (sel)
      2'h0: period_of = PER0_CYC;
      2'h1: period_of = PER1_CYC;
      2'h2: period_of = PER2_CYC;
      default: period_of = PER3_CYC;
    endcase
  endfunction

  // ============================================================
  // Phase timing
  assign measuring = (state_q == dtsr_pkg::DTSR_LOCAL) || (state_q == dtsr_pkg::DTSR_REM1) ||
                     (state_q == dtsr_pkg::DTSR_REM2);
  assign phase_lim = (state_q == dtsr_pkg::DTSR_LOCAL) ? LOCAL_CYC : REMOTE_CYC; // RQ5
  assign phase_done = measuring && (phase_cnt_q == phase_lim - 32'h1);
  assign cycle_start = ((state_q == dtsr_pkg::DTSR_IDLE) && (!standby || one_shot)) || // RQ2 RQ3
                       ((state_q == dtsr_pkg::DTSR_WAIT) && !standby && (per_cnt_q + 32'h1 >= per_lim_q)); // RQ4
  assign state = state_q;

  // ============================================================
  // State machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      dtsr_pkg::DTSR_IDLE: begin
        if (cycle_start) state_d = dtsr_pkg::DTSR_LOCAL;
      end
      dtsr_pkg::DTSR_LOCAL: begin
        if (phase_done) state_d = dtsr_pkg::DTSR_REM1;
      end
      dtsr_pkg::DTSR_REM1: begin
        if (phase_done) state_d = dtsr_pkg::DTSR_REM2;
      end
      dtsr_pkg::DTSR_REM2: begin
        if (phase_done) state_d = dtsr_pkg::DTSR_WAIT;
      end
      dtsr_pkg::DTSR_WAIT: begin
        if (standby) state_d = dtsr_pkg::DTSR_IDLE; // RQ3
        else if (cycle_start) state_d = dtsr_pkg::DTSR_LOCAL;
      end
      default: state_d = dtsr_pkg::DTSR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) state_q <= dtsr_pkg::DTSR_IDLE;
    else state_q <= state_d;
  end

  always_ff @(posedge clk) begin
    if (rst) phase_cnt_q <= 32'h0;
    else if (cycle_start || phase_done) phase_cnt_q <= 32'h0;
    else if (measuring) phase_cnt_q <= phase_cnt_q + 32'h1;
  end

  // Interval latched at cycle start so a mid-cycle change waits
  always_ff @(posedge clk) begin
    if (rst) begin
      per_cnt_q <= 32'h0;
      per_lim_q <= 32'h0;
    end else if (cycle_start) begin
      per_cnt_q <= 32'h0;
      per_lim_q <= period_of(interval_sel); // RQ4 RQ23
    end else if (state_q != dtsr_pkg::DTSR_IDLE) begin
      per_cnt_q <= per_cnt_q + 32'h1;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_standby_hold;
    (state_q == dtsr_pkg::DTSR_IDLE) && standby && !one_shot |=> (state_q == dtsr_pkg::DTSR_IDLE);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("standby left without one-shot"); // RQ2
  property p_one_shot;
    (state_q == dtsr_pkg::DTSR_IDLE) && one_shot |=> (state_q == dtsr_pkg::DTSR_LOCAL);
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot did not start"); // RQ3
  property p_wait;
    (state_q == dtsr_pkg::DTSR_WAIT) && !standby && (per_cnt_q + 32'h1 < per_lim_q) |=>
      (state_q == dtsr_pkg::DTSR_WAIT);
  endproperty
  a_wait: assert property (p_wait) else $error("interval cut short"); // RQ4
  property p_local_len;
    (state_q == dtsr_pkg::DTSR_LOCAL) && (phase_cnt_q != LOCAL_CYC - 32'h1) |=> (state_q == dtsr_pkg::DTSR_LOCAL);
  endproperty
  a_local_len: assert property (p_local_len) else $error("local phase too short"); // RQ5
  c_one_shot: cover property ((state_q == dtsr_pkg::DTSR_IDLE) && standby && one_shot);
endmodule // dtsr_conv_seq

// ===== logic/dtsr_top.sv
// Register map and conversion control of the three-zone temperature sensor
// Assumes an SMBus slave on CLOCK giving command, write and read strobes
`timescale 1ns/100ps
`include "dtsr_defines.svh"
module dtsr_top #(
  parameter logic [31:0] LOCAL_CYC = 32'(`DTSR_LOCAL_US * `DTSR_CLK_MHZ),
  parameter logic [31:0] REMOTE_CYC = 32'(`DTSR_REMOTE_US * `DTSR_CLK_MHZ),
  parameter logic [31:0] PER0_CYC = 32'(`DTSR_PER0_US * `DTSR_CLK_MHZ),
  parameter logic [31:0] PER1_CYC = 32'(`DTSR_PER1_US * `DTSR_CLK_MHZ),
  parameter logic [31:0] PER2_CYC = 32'(`DTSR_PER2_US * `DTSR_CLK_MHZ),
  parameter logic [31:0] PER3_CYC = 32'(`DTSR_PER3_US * `DTSR_CLK_MHZ)
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_BYTE,
  input wire logic WR_VALID,
  input wire logic [7:0] WR_DATA,
  input wire logic RD_REQ,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  input wire logic [9:0] LOCAL_RAW,
  input wire logic [11:0] REMOTE_ONE_RAW,
  input wire logic [11:0] REMOTE_TWO_RAW,
  input wire logic REMOTE_ONE_DIODE_ABSENT,
  input wire logic REMOTE_TWO_DIODE_ABSENT,
  output logic BUSY,
  output logic [2:0] MEAS_ZONE
);
  logic [7:0] ptr_q;
  logic [7:0] cfg_q;
  logic [1:0] fmt_run_q;
  logic [35:0] meta_q;
  logic [35:0] sync_q;
  logic [9:0] local_raw;
  logic [11:0] remote_one_raw;
  logic [11:0] remote_two_raw;
  logic remote_one_absent_in;
  logic remote_two_absent_in;
  logic remote_one_diode_absent_q;
  logic remote_two_diode_absent_q;
  logic remote_one_format;
  logic remote_two_format;
  logic standby_req;
  logic [1:0] conversion_interval_sel;
  logic one_shot;
  logic cycle_start;
  logic phase_done;
  dtsr_pkg::dtsr_state_t state;
  logic [2:0] zone_upd;
  logic [2:0] msb_rd;
  logic [2:0] lsb_rd;
  logic [15:0] pair_in [3];
  logic [7:0] zone_msb [3];
  logic [7:0] zone_lsb [3];
  logic [7:0] status;
  logic [7:0] rd_mux;
  logic [7:0] rd_data_q;
  logic rd_valid_q;

  // Remote result pair from a signed 12-bit reading in eighths of a degree
  function automatic logic [15:0] remote_pair(input logic [11:0] raw, input logic fmt_signed,
                                              input logic absent);
    if (absent) begin
      remote_pair = fmt_signed ? `DTSR_ABS_SIGNED : `DTSR_ABS_UNSIGNED;
    end else if (!fmt_signed) begin
      remote_pair = raw[11] ? 16'h0000 : {raw[10:0], 5'h00};
    end else if (raw[11] != raw[10]) begin
      // Out of signed range clips; negative clip shares the absent pattern
      remote_pair = raw[11] ? `DTSR_ABS_SIGNED : `DTSR_SAT_POS;
    end else begin
      remote_pair = {raw[11], raw[9:0], 5'h00};
    end
  endfunction

  // ============================================================
  // Input synchroniser for the measurement front end
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      meta_q <= 36'h0;
      sync_q <= 36'h0;
    end else begin
      meta_q <= {REMOTE_TWO_DIODE_ABSENT, REMOTE_ONE_DIODE_ABSENT, REMOTE_TWO_RAW, REMOTE_ONE_RAW, LOCAL_RAW};
      sync_q <= meta_q;
    end
  end

  assign local_raw = sync_q[9:0];
  assign remote_one_raw = sync_q[21:10];
  assign remote_two_raw = sync_q[33:22];
  assign remote_one_absent_in = sync_q[34];
  assign remote_two_absent_in = sync_q[35];

  // ============================================================
  // Register pointer and configuration
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) ptr_q <= 8'h00;
    else if (CMD_VALID) ptr_q <= CMD_BYTE; // RQ22
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) cfg_q <= `DTSR_CFG_RESET; // RQ8
    else if (WR_VALID && (ptr_q == `DTSR_REG_CONFIG)) cfg_q <= WR_DATA & `DTSR_CFG_MASK; // RQ1
  end

  assign standby_req = cfg_q[`DTSR_CFG_STANDBY];
  assign conversion_interval_sel = cfg_q[`DTSR_CFG_SEL_HI:`DTSR_CFG_SEL_LO];
  assign remote_two_format = cfg_q[`DTSR_CFG_R2FMT];
  assign remote_one_format = cfg_q[`DTSR_CFG_R1FMT];
  assign one_shot = WR_VALID && (ptr_q == `DTSR_REG_ONESHOT); // RQ21

  // Formats held for the whole cycle
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) fmt_run_q <= 2'h0;
    else if (cycle_start) fmt_run_q <= {remote_two_format, remote_one_format}; // RQ23
  end

  // ============================================================
  // Conversion sequencing
  dtsr_conv_seq #(
    .LOCAL_CYC(LOCAL_CYC),
    .REMOTE_CYC(REMOTE_CYC),
    .PER0_CYC(PER0_CYC),
    .PER1_CYC(PER1_CYC),
    .PER2_CYC(PER2_CYC),
    .PER3_CYC(PER3_CYC)
  ) u_seq (
    .clk(CLOCK),
    .rst(SYS_RST),
    .standby(standby_req),
    .one_shot(one_shot),
    .interval_sel(conversion_interval_sel),
    .state(state),
    .cycle_start(cycle_start),
    .phase_done(phase_done)
  );

  assign MEAS_ZONE = {state == dtsr_pkg::DTSR_REM2, state == dtsr_pkg::DTSR_REM1, state == dtsr_pkg::DTSR_LOCAL};
  assign BUSY = |MEAS_ZONE; // RQ19
  assign zone_upd = {3{phase_done}} & MEAS_ZONE;

  // ============================================================
  // Result formatting and zone registers
  always_comb begin
    pair_in[0] = {local_raw, 6'h00}; // RQ9 RQ10
    pair_in[1] = remote_pair(remote_one_raw, fmt_run_q[0], remote_one_absent_in); // RQ7 RQ11 RQ12 RQ13
    pair_in[2] = remote_pair(remote_two_raw, fmt_run_q[1], remote_two_absent_in); // RQ6 RQ11 RQ12 RQ13
  end

  assign msb_rd = {3{RD_REQ}} & {ptr_q == `DTSR_REG_R2_HI, ptr_q == `DTSR_REG_R1_HI, ptr_q == `DTSR_REG_LOCAL_HI};
  assign lsb_rd = {3{RD_REQ}} & {ptr_q == `DTSR_REG_R2_LO, ptr_q == `DTSR_REG_R1_LO, ptr_q == `DTSR_REG_LOCAL_LO};

  for (genvar z = 0; z < 3; z++) begin : g_zone
    dtsr_zone_regs u_zone (
      .clk(CLOCK),
      .rst(SYS_RST),
      .upd(zone_upd[z]),
      .msb_in(pair_in[z][15:8]),
      .lsb_in(pair_in[z][7:0]),
      .msb_rd(msb_rd[z]),
      .lsb_rd(lsb_rd[z]),
      .msb(zone_msb[z]),
      .lsb(zone_lsb[z])
    );
  end

  // ============================================================
  // Missing diode flags
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      remote_one_diode_absent_q <= 1'b0;
      remote_two_diode_absent_q <= 1'b0;
    end else begin
      if (zone_upd[1]) remote_one_diode_absent_q <= remote_one_absent_in; // RQ20
      if (zone_upd[2]) remote_two_diode_absent_q <= remote_two_absent_in; // RQ20
    end
  end

  assign status = {BUSY, 5'h00, remote_two_diode_absent_q, remote_one_diode_absent_q}; // RQ19

  // ============================================================
  // Read path
  always_comb begin
    rd_mux = 8'h00;
    if (ptr_q == `DTSR_REG_STATUS) begin
      rd_mux = status;
    end else if (ptr_q == `DTSR_REG_CONFIG) begin
      rd_mux = cfg_q; // RQ1
    end else if (ptr_q == `DTSR_REG_LOCAL_HI) begin
      rd_mux = zone_msb[0];
    end else if (ptr_q == `DTSR_REG_R1_HI) begin
      rd_mux = zone_msb[1];
    end else if (ptr_q == `DTSR_REG_R2_HI) begin
      rd_mux = zone_msb[2];
    end else if (ptr_q == `DTSR_REG_LOCAL_LO) begin
      rd_mux = zone_lsb[0];
    end else if (ptr_q == `DTSR_REG_R1_LO) begin
      rd_mux = zone_lsb[1];
    end else if (ptr_q == `DTSR_REG_R2_LO) begin
      rd_mux = zone_lsb[2];
    end else if (ptr_q == `DTSR_REG_MAKER) begin
      rd_mux = `DTSR_MAKER_ID; // RQ17
    end else if (ptr_q == `DTSR_REG_REV) begin
      rd_mux = `DTSR_REVISION; // RQ18
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q <= RD_REQ ? rd_mux : 8'h00;
      rd_valid_q <= RD_REQ;
    end
  end

  assign RD_DATA = rd_data_q;
  assign RD_VALID = rd_valid_q;

  // ============================================================
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  property p_cfg_reserved;
    RD_REQ && (ptr_q == `DTSR_REG_CONFIG) |=> RD_VALID && ((RD_DATA & 8'h89) == 8'h00);
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved) else $error("reserved config bit set"); // RQ1
  property p_cfg_reset;
    SYS_RST |=> (cfg_q == 8'h00);
  endproperty
  a_cfg_reset: assert property (disable iff (1'b0) p_cfg_reset) else $error("config not cleared"); // RQ8
  property p_local_hi;
    zone_upd[0] |=> (zone_msb[0] == $past(local_raw[9:2]));
  endproperty
  a_local_hi: assert property (p_local_hi) else $error("local high byte wrong"); // RQ9
  property p_low_zero;
    RD_REQ && ((ptr_q == `DTSR_REG_R1_LO) || (ptr_q == `DTSR_REG_R2_LO)) |=> (RD_DATA[4:0] == 5'h00);
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("remote low unused bits set"); // RQ13
  property p_local_lo_zero;
    RD_REQ && (ptr_q == `DTSR_REG_LOCAL_LO) |=> (RD_DATA[5:0] == 6'h00);
  endproperty
  a_local_lo_zero: assert property (p_local_lo_zero) else $error("local low unused bits set"); // RQ10
  property p_unsigned;
    zone_upd[1] && !fmt_run_q[0] && !remote_one_absent_in && !remote_one_raw[11] |=>
      (zone_msb[1] == $past(remote_one_raw[10:3]));
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("unsigned high byte wrong"); // RQ12
  property p_signed;
    zone_upd[2] && fmt_run_q[1] && !remote_two_absent_in && (remote_two_raw[11] == remote_two_raw[10]) |=>
      (zone_msb[2] == {$past(remote_two_raw[11]), $past(remote_two_raw[9:3])});
  endproperty
  a_signed: assert property (p_signed) else $error("signed high byte wrong"); // RQ11
  property p_absent;
    zone_upd[1] && remote_one_absent_in |=> remote_one_diode_absent_q &&
      (zone_msb[1] == (fmt_run_q[0] ? 8'h80 : 8'hFF));
  endproperty
  a_absent: assert property (p_absent) else $error("missing diode not flagged"); // RQ20
  property p_busy;
    RD_REQ && (ptr_q == `DTSR_REG_STATUS) |=> (RD_DATA[7] == $past(BUSY));
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit mismatch"); // RQ19
  property p_one_shot_zero;
    RD_REQ && (ptr_q == `DTSR_REG_ONESHOT) |=> (RD_DATA == 8'h00);
  endproperty
  a_one_shot_zero: assert property (p_one_shot_zero) else $error("one-shot read nonzero"); // RQ21
  property p_ident;
    RD_REQ && (ptr_q == `DTSR_REG_MAKER) |=> (RD_DATA == `DTSR_MAKER_ID);
  endproperty
  a_ident: assert property (p_ident) else $error("maker identity wrong"); // RQ17
  property p_pointer;
    CMD_VALID |=> (ptr_q == $past(CMD_BYTE));
  endproperty
  a_pointer: assert property (p_pointer) else $error("pointer not loaded"); // RQ22
  property p_fmt_hold;
    !cycle_start |=> $stable(fmt_run_q);
  endproperty
  a_fmt_hold: assert property (p_fmt_hold) else $error("format changed mid-cycle"); // RQ23
  c_absent: cover property (zone_upd[2] && remote_two_absent_in);
  c_signed: cover property (zone_upd[1] && fmt_run_q[0]);
  c_interval: cover property (cycle_start && (conversion_interval_sel == 2'h3));
endmodule // dtsr_top

// ===== logic/dtsr_zone_regs.sv
// Result byte pair of one zone with low byte freeze on high byte read
// Assumes single-cycle update and read strobes on clk
`timescale 1ns/100ps
module dtsr_zone_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic upd,
  input wire logic [7:0] msb_in,
  input wire logic [7:0] lsb_in,
  input wire logic msb_rd,
  input wire logic lsb_rd,
  output logic [7:0] msb,
  output logic [7:0] lsb
);
  logic [7:0] msb_q;
  logic [7:0] lsb_q;
  logic [7:0] held_q;
  logic locked_q;

  // ============================================================
  // Live result
  always_ff @(posedge clk) begin
    if (rst) begin
      msb_q <= 8'h00;
      lsb_q <= 8'h00;
    end else if (upd) begin
      msb_q <= msb_in;
      lsb_q <= lsb_in;
    end
  end

  // ============================================================
  // Freeze and release
  always_ff @(posedge clk) begin
    if (rst) begin
      locked_q <= 1'b0;
      held_q <= 8'h00;
    end else if (msb_rd) begin
      locked_q <= 1'b1; // RQ14
      held_q <= lsb_q; // RQ16
    end else if (lsb_rd) begin
      locked_q <= 1'b0; // RQ15
    end
  end

  assign msb = msb_q;
  assign lsb = locked_q ? held_q : lsb_q;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_refreeze;
    msb_rd |=> locked_q && (held_q == $past(lsb_q));
  endproperty
  a_refreeze: assert property (p_refreeze) else $error("low byte not refrozen"); // RQ16
  property p_hold;
    msb_rd ##1 (!msb_rd && !lsb_rd) [*3] |-> $stable(lsb);
  endproperty
  a_hold: assert property (p_hold) else $error("frozen low byte moved"); // RQ14
  property p_release;
    lsb_rd && !msb_rd |=> (lsb == lsb_q);
  endproperty
  a_release: assert property (p_release) else $error("low byte not released"); // RQ15
  property p_pair_read;
    msb_rd ##[1:4] lsb_rd;
  endproperty
  c_pair_read: cover property (p_pair_read);
endmodule // dtsr_zone_regs

// ===== pkg/dtsr_defines.svh
// Constants of the three-zone temperature register block
// Assumes a 125 MHz core clock and a command-byte register pointer
//
// Overview of operation
// RQ1: Configuration bits 7, 3 and 0 always read back as zero.
// RQ2: Standby bit one stops automatic conversions; zero converts at the chosen interval.
// RQ3: In standby a one-shot write runs one conversion of all zones.
// RQ4: Interval bits select 66 ms continuous, 200 ms, 1 s or 3 s.
// RQ5: Each remote measurement lasts 26 ms, the local one 14 ms.
// RQ6: Zone two format bit picks unsigned or two's-complement results.
// RQ7: Zone one format bit picks unsigned or two's-complement results.
// RQ8: Power-up clears every configuration bit to zero.
// RQ9: Local high byte holds sign and integer degrees 64 down to 1.
// RQ10: Local low byte holds 0.5 and 0.25 fractions, zero below.
// RQ11: Signed remote high byte holds sign and integer degrees 64 to 1.
// RQ12: Unsigned remote high byte holds integer degrees 128 down to 1.
// RQ13: Remote low byte holds 0.5, 0.25, 0.125 fractions, zero below.
// RQ14: Reading a high byte freezes its low byte for a coherent pair.
// RQ15: Reading a frozen low byte releases it to later updates.
// RQ16: Each high byte read refreezes its own zone's low byte.
// RQ17: Maker identity register returns a fixed value.
// RQ18: Die revision register returns a fixed code.
// RQ19: Status bit 7 reads one while a conversion runs.
// RQ20: Missing diode sets its status flag and forces FFE0h or 8000h.
// RQ21: One-shot register acts on write only and reads zero.
// RQ22: Command byte sets the pointer used by later reads and writes.
// RQ23: Interval or format changes apply from the next conversion cycle.
`ifndef DTSR_DEFINES_SVH
`define DTSR_DEFINES_SVH
// ============================================================
// Register pointer values
`define DTSR_REG_STATUS 8'h02
`define DTSR_REG_CONFIG 8'h03
`define DTSR_REG_ONESHOT 8'h0F
`define DTSR_REG_LOCAL_HI 8'h10
`define DTSR_REG_R1_HI 8'h11
`define DTSR_REG_R2_HI 8'h12
`define DTSR_REG_LOCAL_LO 8'h20
`define DTSR_REG_R1_LO 8'h21
`define DTSR_REG_R2_LO 8'h22
`define DTSR_REG_MAKER 8'hFE
`define DTSR_REG_REV 8'hFF
// ============================================================
// Configuration register fields
`define DTSR_CFG_MASK 8'h76
`define DTSR_CFG_RESET 8'h00
`define DTSR_CFG_STANDBY 6
`define DTSR_CFG_SEL_HI 5
`define DTSR_CFG_SEL_LO 4
`define DTSR_CFG_R2FMT 2
`define DTSR_CFG_R1FMT 1
// ============================================================
// Identity values, arbitrary
`define DTSR_MAKER_ID 8'h5A
`define DTSR_REVISION 8'h3C
// ============================================================
// Result patterns
`define DTSR_ABS_UNSIGNED 16'hFFE0
`define DTSR_ABS_SIGNED 16'h8000
`define DTSR_SAT_POS 16'h7FE0
// ============================================================
// Timing
`define DTSR_CLK_MHZ 125
`define DTSR_LOCAL_US 14000
`define DTSR_REMOTE_US 26000
`define DTSR_PER0_US 66000
`define DTSR_PER1_US 200000
`define DTSR_PER2_US 1000000
`define DTSR_PER3_US 3000000
`endif

// ===== pkg/dtsr_pkg.sv
// Types of the three-zone temperature register block
// Assumes nothing beyond the constants header
package dtsr_pkg;
  typedef enum logic [2:0] {
    DTSR_IDLE = 3'h0,
    DTSR_LOCAL = 3'h1,
    DTSR_REM1 = 3'h2,
    DTSR_REM2 = 3'h3,
    DTSR_WAIT = 3'h4
  } dtsr_state_t;
endpackage

// ===== testbench/dtsr_host.sv
// Host stand-in giving command, write and read strobes
// Assumes the block samples strobes on rising clk
`timescale 1ns/100ps
module dtsr_host (
  input wire logic clk,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_req,
  input wire logic [7:0] rd_data
);
  // ==========
  // Idle levels
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_req = 1'b0;
  end
  // ==========
  // Bus cycles
  task automatic put_ptr(input logic [7:0] a);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_byte <= a;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~a;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put_ptr(a);
    wr_valid <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_valid <= 1'b0;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put_ptr(a);
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
    d = rd_data;
  endtask
endmodule // dtsr_host

// ===== testbench/tb_top.sv
// Self-checking bench of the register block
// Assumes short conversion counts set below
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cv, wv, rq, rv, busy, ab1, ab2;
  logic [7:0] cb, wd, rdd;
  logic [2:0] mz;
  logic [9:0] lraw = 10'h257;
  logic [11:0] r1 = 12'h5AD;
  logic [11:0] r2 = 12'hF00;
  int error_cnt = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  dtsr_host u_dtsr_host (.clk(clk), .cmd_valid(cv), .cmd_byte(cb), .wr_valid(wv),
    .wr_data(wd), .rd_req(rq), .rd_data(rdd));
  dtsr_top #(.LOCAL_CYC(32'h4), .REMOTE_CYC(32'h6), .PER0_CYC(32'h10), .PER1_CYC(32'h1E),
    .PER2_CYC(32'h28)) u_dtsr_top (.CLOCK(clk), .SYS_RST(rst),
    .CMD_VALID(cv), .CMD_BYTE(cb), .WR_VALID(wv), .WR_DATA(wd), .RD_REQ(rq),
    .RD_DATA(rdd), .RD_VALID(rv), .LOCAL_RAW(lraw), .REMOTE_ONE_RAW(r1),
    .REMOTE_TWO_RAW(r2), .REMOTE_ONE_DIODE_ABSENT(ab1), .REMOTE_TWO_DIODE_ABSENT(ab2),
    .BUSY(busy), .MEAS_ZONE(mz));
  // ==========
  // Helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    logic [7:0] d;
    u_dtsr_host.rd(a, d);
    chk8(d & m, e);
    chk8({7'h00, rv}, 8'h01);
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    #1;
    while (busy !== lvl && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400) chk8({7'h00, busy}, {7'h00, lvl});
  endtask
  task automatic wait_conv;
    repeat (2) begin
      wait_busy(1'b1);
      wait_busy(1'b0);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_map;
    rc(8'h03, 8'h00);
    rc(8'hFE, 8'h5A);
    rc(8'hFF, 8'h3C);
    rc(8'h0F, 8'h00);
    rc(8'h40, 8'h00);
    u_dtsr_host.wr(8'h03, 8'hFF);
    rc(8'h03, 8'h76);
  endtask
  task automatic t_fmt;
    u_dtsr_host.wr(8'h03, 8'h06);
    wait_conv();
    rc(8'h10, 8'h95);
    rc(8'h20, 8'hC0);
    rc(8'h11, 8'h7F);
    rc(8'h21, 8'hE0);
    rc(8'h12, 8'hE0);
    rc(8'h22, 8'h00);
    u_dtsr_host.wr(8'h03, 8'h00);
    wait_conv();
    rc(8'h11, 8'hB5);
    rc(8'h21, 8'hA0);
    rc(8'h12, 8'h00);
  endtask
  task automatic t_lock;
    rc(8'h11, 8'hB5);
    @(posedge clk) r1 <= 12'h3A8;
    lraw <= 10'h0A1;
    r2 <= 12'h0FD;
    wait_conv();
    rc(8'h11, 8'h75);
    rc(8'h21, 8'h00);
    rc(8'h10, 8'h28);
    rc(8'h20, 8'h40);
    rc(8'h12, 8'h1F);
    rc(8'h22, 8'hA0);
    rc(8'h11, 8'h75);
    @(posedge clk) r1 <= 12'h5AD;
    wait_conv();
    rc(8'h21, 8'h00);
    rc(8'h21, 8'hA0);
  endtask
  task automatic t_absent;
    @(posedge clk) ab1 <= 1'b1;
    ab2 <= 1'b1;
    wait_conv();
    rc(8'h11, 8'hFF);
    rc(8'h21, 8'hE0);
    rc(8'h12, 8'hFF);
    rc(8'h22, 8'hE0);
    rc(8'h02, 8'h03, 8'h03);
    u_dtsr_host.wr(8'h03, 8'h06);
    wait_conv();
    rc(8'h11, 8'h80);
    rc(8'h02, 8'h03, 8'h03);
    @(posedge clk) ab1 <= 1'b0;
    ab2 <= 1'b0;
  endtask
  task automatic t_rate;
    int n;
    n = 0;
    u_dtsr_host.wr(8'h03, 8'h10);
    wait_conv();
    while (busy === 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk8(8'(n), 8'h0E);
  endtask
  task automatic t_shot;
    u_dtsr_host.wr(8'h03, 8'h40);
    wait_busy(1'b0);
    repeat (60) @(posedge clk);
    #1 chk8({7'h00, busy}, 8'h00);
    u_dtsr_host.wr(8'h0F, 8'hA5);
    #1 chk8({7'h00, busy}, 8'h01);
    chk8({5'h00, mz}, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk8({5'h00, mz}, 8'h01);
    @(posedge clk);
    #1 chk8({5'h00, mz}, 8'h02);
    rc(8'h02, 8'h80, 8'h80);
    wait_busy(1'b0);
    repeat (60) @(posedge clk);
    #1 chk8({7'h00, busy}, 8'h00);
    rc(8'h02, 8'h00, 8'h83);
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    ab1 = 1'b0;
    ab2 = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_map();
    t_fmt();
    t_lock();
    t_absent();
    t_rate();
    t_shot();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule // tb_top
